// ===== lp_sr_cfg.svh
// Constants for the self-refresh and register-read block.
// Assumes inclusion by the package and modules of this block only.
`ifndef LP_SR_CFG_SVH
`define LP_SR_CFG_SVH
`define CLK_PERIOD_NS        20
`define CKE_INT_DELAY_CYC    2
`define MIN_SR_TIME_NS       100
`define MIN_SR_CYC           ((`MIN_SR_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SR_EXIT_DELAY_NS     200
`define SR_EXIT_CYC          ((`SR_EXIT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define READ_LATENCY_CYC     8
`define BURST_BEATS          8
`define NUM_BANKS            8
`define NUM_SEGMENTS         8
`define BANK_MASK_IDX        8'h10
`define SEG_MASK_IDX         8'h11
`define RSVD_MASK_IDX        8'h12
`define CAL_A_IDX            8'h20
`define CAL_B_IDX            8'h28
`define CAL_A_PATTERN        8'h55
`define CAL_B_PATTERN        8'hcc
`define MASK_RESET           8'h00
`endif

// ===== lp_sr_pkg.sv
// Types for the self-refresh and register-read block.
// Assumes the configuration header is available on the include path.
`include "lp_sr_cfg.svh"
package lp_sr_pkg;
	// Power state of the device.
	typedef enum logic [2:0] {
		ST_IDLE    = 3'b000,
		ST_CKE_DLY = 3'b001,
		ST_SELF    = 3'b010,
		ST_EXIT    = 3'b011
	} pwr_state_e;

	// Command-address bus as sampled on both clock edges.
	typedef struct packed {
		logic       cs_n;
		logic [9:0] rise;
		logic [9:0] fall;
	} ca_cmd_s;

	// Read data burst toward the controller.
	typedef struct packed {
		logic        valid;
		logic [31:0] dq;
		logic [3:0]  dqs;
	} rd_beat_s;
endpackage : lp_sr_pkg

// ===== lp_sr_regfile.sv
// Small store of mode register bytes written by register writes.
// Assumes one write port and one registered read port on one clock.
`include "lp_sr_cfg.svh"
module lp_sr_regfile #(
	parameter int DEPTH = 64
) (
	// Clock and reset.
	input  wire logic                     core_clk_i,
	input  wire logic                     sys_rst_i,
	// Write port.
	input  wire logic                     wr_en_i,
	input  wire logic [$clog2(DEPTH)-1:0] wr_idx_i,
	input  wire logic [7:0]               wr_data_i,
	// Read port.
	input  wire logic [$clog2(DEPTH)-1:0] rd_idx_i,
	output logic      [7:0]               rd_data_o
);
	logic [7:0] mem [DEPTH];

	// Stores written bytes.
	always_ff @(posedge core_clk_i) begin
		if (wr_en_i) begin
			mem[wr_idx_i] <= wr_data_i;
		end
	end

	// Registered read, cleared by reset.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rd_data_o <= 8'h00;
		end else begin
			rd_data_o <= mem[rd_idx_i];
		end
	end
endmodule : lp_sr_regfile

// ===== lp_sr_dev.sv
// Device-side self refresh, partial array retention and register read.
// Assumes a controller that keeps its own timing obligations.
// Notes on behaviour
// - Self-refresh entry: cke low, cs low, bits 0,1 low, bit 2 high.
// - After the internal cke delay, inputs except cke are ignored.
// - Device refreshes all unmasked banks once within minimum self-refresh time.
// - Bank mask register: masked banks get no self refresh.
// - Segment mask blocks that segment in every unmasked bank.
// - Writes to the reserved mask register change nothing.
// - Register read: cs low, bits 0..2 low, bit 3 high; index decoded.
// - Register byte on data 7..0 in first beat after read latency.
// - All strobes toggle through the register read burst.
// - Register read burst is eight beats and is never interrupted.
// - Per-bank refresh counter steps round robin, cleared at exit.
// - Refresh with bit 3 low is per bank, high is all bank.
`include "lp_sr_cfg.svh"
module lp_sr_dev
	import lp_sr_pkg::*;
#(
	parameter int MIN_SR_CYC  = `MIN_SR_CYC,
	parameter int SR_EXIT_CYC = `SR_EXIT_CYC,
	parameter int READ_LAT_CYC = `READ_LATENCY_CYC
) (
	// Clock and reset.
	input  wire logic       core_clk_i,
	input  wire logic       sys_rst_i,
	// Controller command side.
	input  wire logic       cke_i,
	input  wire ca_cmd_s    cmd_i,
	// Read data side.
	output rd_beat_s        rd_o,
	// Status.
	output logic            self_refresh_o,
	output logic [2:0]      bank_ptr_o,
	output logic [7:0]      refresh_done_o,
	output logic [7:0]      bank_retain_o,
	output logic [7:0]      seg_retain_o
);
	// ****************************************
	// Command decode
	// ****************************************
	function automatic logic is_refresh(ca_cmd_s c);
		return !c.cs_n && !c.rise[0] && !c.rise[1] && c.rise[2];
	endfunction : is_refresh

	function automatic logic [7:0] reg_index(ca_cmd_s c);
		return {c.rise[9:4], c.fall[1:0]};
	endfunction : reg_index

	pwr_state_e state;
	logic       cke_q;
	logic [15:0] cnt;
	logic       inputs_on;
	logic       sr_entry;
	logic       rd_cmd;
	logic       wr_cmd;
	logic       ref_cmd;

	// Receivers are enabled outside the quiet part of self refresh.
	assign inputs_on = (state == ST_IDLE) || (state == ST_EXIT);
	assign sr_entry  = cke_q && !cke_i && is_refresh(cmd_i);
	assign ref_cmd   = inputs_on && cke_i && is_refresh(cmd_i);
	assign rd_cmd    = inputs_on && cke_i && !cmd_i.cs_n
		&& cmd_i.rise[3:0] == 4'b1000;
	assign wr_cmd    = inputs_on && cke_i && !cmd_i.cs_n
		&& cmd_i.rise[3:0] == 4'b0000;

	// Previous cycle clock enable.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			cke_q <= 1'b1;
		end else begin
			cke_q <= cke_i;
		end
	end

	// ****************************************
	// Power state machine
	// ****************************************
	// Tracks entry, internal delay, self refresh and exit wait.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			state <= ST_IDLE;
			cnt   <= 16'h0000;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (sr_entry && state == ST_IDLE) begin
						state <= ST_CKE_DLY;
						cnt   <= 16'h0000;
					end
				end
				ST_CKE_DLY: begin
					cnt <= cnt + 16'h0001;
					if (cnt == 16'(`CKE_INT_DELAY_CYC - 1)) begin
						state <= ST_SELF;
						cnt   <= 16'h0000;
					end
				end
				ST_SELF: begin
					if (cnt != 16'hffff) begin
						cnt <= cnt + 16'h0001;
					end
					if (cke_i) begin
						state <= ST_EXIT;
						cnt   <= 16'h0000;
					end
				end
				ST_EXIT: begin
					cnt <= cnt + 16'h0001;
					if (cnt == 16'(SR_EXIT_CYC - 1)) begin
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Self-refresh status flag.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			self_refresh_o <= 1'b0;
		end else begin
			self_refresh_o <= (state == ST_CKE_DLY) || (state == ST_SELF);
		end
	end

	// ****************************************
	// Mask registers
	// ****************************************
	logic [7:0] bank_mask;
	logic [7:0] seg_mask;

	// Register writes reach the masks; the reserved unit is dropped.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bank_mask <= `MASK_RESET;
			seg_mask  <= `MASK_RESET;
		end else if (wr_cmd) begin
			if (reg_index(cmd_i) == `BANK_MASK_IDX) begin
				bank_mask <= cmd_i.fall[9:2];
			end
			if (reg_index(cmd_i) == `SEG_MASK_IDX) begin
				seg_mask <= cmd_i.fall[9:2];
			end
		end
	end

	// Retention view: bank is kept if unmasked, segment for kept banks.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bank_retain_o <= 8'hff;
			seg_retain_o  <= 8'hff;
		end else begin
			bank_retain_o <= ~bank_mask;
			seg_retain_o  <= (bank_mask == 8'hff) ? 8'h00 : ~seg_mask;
		end
	end

	// ****************************************
	// Internal refresh and bank counter
	// ****************************************
	// One internal refresh per self-refresh period in unmasked banks.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			refresh_done_o <= 8'h00;
		end else if (state == ST_SELF && cnt == 16'h0000) begin
			refresh_done_o <= ~bank_mask;
		end else if (state == ST_IDLE && sr_entry) begin
			refresh_done_o <= 8'h00;
		end
	end

	// Round robin per-bank pointer, zeroed by all-bank refresh and exit.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			bank_ptr_o <= 3'h0;
		end else if (state == ST_SELF && cke_i) begin
			bank_ptr_o <= 3'h0;
		end else if (ref_cmd && !cmd_i.rise[3]) begin
			bank_ptr_o <= bank_ptr_o + 3'h1;
		end else if (ref_cmd && cmd_i.rise[3]) begin
			bank_ptr_o <= 3'h0;
		end
	end

	// ****************************************
	// Register read path
	// ****************************************
	logic [7:0] rf_data;
	logic [7:0] rd_idx;
	logic [4:0] lat_cnt;
	logic       lat_run;
	logic [3:0] beat;
	logic       burst;
	logic [7:0] cmd_idx;

	// Register index carried by the command on the bus this cycle.
	assign cmd_idx = reg_index(cmd_i);

	lp_sr_regfile #(
		.DEPTH (64)
	) u_regfile (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.wr_en_i    (wr_cmd && reg_index(cmd_i) != `RSVD_MASK_IDX),
		.wr_idx_i   (cmd_idx[5:0]),
		.wr_data_i  (cmd_i.fall[9:2]),
		.rd_idx_i   (rd_idx[5:0]),
		.rd_data_o  (rf_data)
	);

	// Latches the index and counts the read latency.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			rd_idx  <= 8'h00;
			lat_cnt <= 5'h00;
			lat_run <= 1'b0;
		end else if (rd_cmd && !lat_run && !burst) begin
			rd_idx  <= reg_index(cmd_i);
			lat_cnt <= 5'h00;
			lat_run <= 1'b1;
		end else if (lat_run) begin
			lat_cnt <= lat_cnt + 5'h01;
			if (lat_cnt == 5'(READ_LAT_CYC - 2)) begin
				lat_run <= 1'b0;
			end
		end
	end

	// Eight beat burst with toggling strobes.
	always_ff @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			burst <= 1'b0;
			beat  <= 4'h0;
			rd_o  <= '0;
		end else if (lat_run && lat_cnt == 5'(READ_LAT_CYC - 2)) begin
			burst <= 1'b1;
			beat  <= 4'h1;
			rd_o.valid <= 1'b1;
			rd_o.dqs   <= 4'hf;
			rd_o.dq    <= cal_or_reg(rd_idx, rf_data, 3'h0);
		end else if (burst) begin
			rd_o.dqs <= ~rd_o.dqs;
			rd_o.dq  <= cal_or_reg(rd_idx, 8'h00, beat[2:0]);
			beat     <= beat + 4'h1;
			if (beat == 4'(`BURST_BEATS)) begin
				burst <= 1'b0;
				rd_o  <= '0;
			end
		end
	end

	// Register byte on the first beat, calibration bits on all beats.
	// Bit b of a pattern constant is the level of beat b on every lane.
	function automatic logic [31:0] cal_or_reg(logic [7:0] idx,
		logic [7:0] val, logic [2:0] b);
		logic [7:0] pat_a;
		logic [7:0] pat_b;
		pat_a = `CAL_A_PATTERN;
		pat_b = `CAL_B_PATTERN;
		if (idx == `CAL_A_IDX) begin
			return {32{pat_a[b]}};
		end
		if (idx == `CAL_B_IDX) begin
			return {32{pat_b[b]}};
		end
		return {24'h000000, val};
	endfunction : cal_or_reg

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);

	entry_decode_a: assert property (state == ST_IDLE && sr_entry
		|=> state == ST_CKE_DLY) else $error("entry missed");
	quiet_inputs_a: assert property (state == ST_SELF |-> !rd_cmd && !wr_cmd)
		else $error("input seen in self refresh");
	quiet_masks_a: assert property (state == ST_SELF
		|=> $stable(bank_mask) && $stable(seg_mask))
		else $error("mask changed in self refresh");
	delay_len_a: assert property ($rose(state == ST_CKE_DLY)
		|-> ##2 state == ST_SELF) else $error("delay wrong");
	int_refresh_a: assert property ($rose(state == ST_SELF)
		|=> refresh_done_o == ~bank_mask) else $error("no refresh");
	sr_refresh_win_a: assert property ($rose(state == ST_SELF)
		|-> ##[1:MIN_SR_CYC] refresh_done_o == ~bank_mask)
		else $error("no refresh within minimum stay");
	retain_bank_a: assert property (##1 bank_retain_o == ~$past(bank_mask))
		else $error("retain wrong");
	burst_len_a: assert property ($rose(burst) |-> burst[*8] ##1 !burst)
		else $error("burst length");
	strobe_tog_a: assert property (burst && $past(burst)
		|-> rd_o.dqs == ~$past(rd_o.dqs)) else $error("strobe");
	ptr_clear_a: assert property (state == ST_SELF && cke_i
		|=> bank_ptr_o == 3'h0) else $error("pointer");
	read_lat_a: assert property (rd_cmd && !lat_run && !burst
		|-> ##READ_LAT_CYC rd_o.valid) else $error("read latency");

	sr_cycle_c: cover property (state == ST_EXIT ##1 state == ST_IDLE);
	reg_read_c: cover property ($rose(burst));
	cal_c: cover property (burst && rd_idx == `CAL_A_IDX);
	mask_c: cover property (wr_cmd && reg_index(cmd_i) == `BANK_MASK_IDX);
endmodule : lp_sr_dev

// ===== lp_sr_ctl_model.sv
// Behavioural memory controller driving the device command side.
// Assumes every task is called at a rising edge of core_clk_i.
`include "lp_sr_cfg.svh"
module lp_sr_ctl_model
	import lp_sr_pkg::*;
#(
	parameter int MIN_SR_CYC  = 5,
	parameter int SR_EXIT_CYC = 10
) (
	// Clock.
	input  wire logic core_clk_i,
	// Command side toward the device.
	output logic      cke_o,
	output ca_cmd_s   cmd_o
);
	//**********************************************************************
	// Command tasks
	//**********************************************************************
	// Start idle with clock enable high and the device deselected.
	initial begin
		cke_o = 1'b1;
		cmd_o = '{cs_n: 1'b1, rise: 10'h155, fall: 10'h2aa};
	end

	// Set one command just after an edge and hold it to the taking edge.
	task automatic drive(input logic cke, input logic cs_n,
		input logic [9:0] r, input logic [9:0] f);
		#1;
		cke_o = cke;
		cmd_o = '{cs_n: cs_n, rise: r, fall: f};
		@(posedge core_clk_i);
	endtask : drive

	// Deselected cycles; the bus keeps changing as its value is undefined.
	task automatic nop(input int n);
		repeat (n) drive(cke_o, 1'b1, ~cmd_o.rise, ~cmd_o.fall);
	endtask : nop

	// Register write followed by idle cycles.
	task automatic reg_write(input logic [7:0] idx, input logic [7:0] d);
		drive(cke_o, 1'b0, {idx[7:2], 4'h0}, {d, idx[1:0]});
		nop(2);
	endtask : reg_write

	// Register read command; the caller idles the bus over the burst.
	task automatic reg_read(input logic [7:0] idx);
		drive(1'b1, 1'b0, {idx[7:2], 4'h8}, {8'h00, idx[1:0]});
	endtask : reg_read

	// Per-bank refresh when all is low, all-bank refresh when high.
	task automatic refresh(input logic all);
		drive(1'b1, 1'b0, {6'h00, all, 3'b100}, 10'h000);
		nop(1);
	endtask : refresh

	// Entry from idle banks, no access running, then a minimum stay.
	task automatic sr_enter();
		drive(1'b0, 1'b0, 10'h004, 10'h000);
		nop(2);
		nop(MIN_SR_CYC);
	endtask : sr_enter

	// Exit after stable clocks, then nops with cke high over the wait.
	task automatic sr_exit();
		nop(2);
		drive(1'b1, 1'b1, ~cmd_o.rise, ~cmd_o.fall);
		nop(SR_EXIT_CYC);
	endtask : sr_exit
endmodule : lp_sr_ctl_model

// ===== dram_self_refresh_mode_read_tb.sv
// Self-checking bench for the self-refresh and register-read device.
// Assumes the controller model drives all command inputs.
`include "lp_sr_cfg.svh"
module dram_self_refresh_mode_read_tb
	import lp_sr_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	//**********************************************************************
	// Bench signals
	//**********************************************************************
	localparam int MIN_SR  = 5;
	localparam int SR_EXIT = 10;
	localparam int READ_LAT = `READ_LATENCY_CYC;
	logic       core_clk_i;
	logic       sys_rst_i;
	logic       cke;
	ca_cmd_s    cmd;
	rd_beat_s   rd;
	logic       self_refresh;
	logic [2:0] bank_ptr;
	logic [7:0] refresh_done;
	logic [7:0] bank_retain;
	logic [7:0] seg_retain;
	int         failures;
	int         n_checks;
	int         cycles;

	lp_sr_dev #(.MIN_SR_CYC(MIN_SR), .SR_EXIT_CYC(SR_EXIT),
		.READ_LAT_CYC(READ_LAT)) dut_u (
		.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i), .cke_i(cke),
		.cmd_i(cmd), .rd_o(rd), .self_refresh_o(self_refresh),
		.bank_ptr_o(bank_ptr), .refresh_done_o(refresh_done),
		.bank_retain_o(bank_retain), .seg_retain_o(seg_retain));
	lp_sr_ctl_model #(.MIN_SR_CYC(MIN_SR), .SR_EXIT_CYC(SR_EXIT)) ctl_u (
		.core_clk_i(core_clk_i), .cke_o(cke), .cmd_o(cmd));

	// Clock and a cycle ceiling that cuts a hang short.
	initial begin
		core_clk_i = 1'b0;
		forever #10 core_clk_i = ~core_clk_i;
	end
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			failures++;
			finish_test();
		end
	end

	//**********************************************************************
	// Helper tasks
	//**********************************************************************
	// Compare and count.
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : check

	// Verdict and end of run.
	task automatic finish_test();
		$display("Checks %0d, mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : finish_test

	// Watch one burst after a read command edge; the i-th falling edge
	// shows what the controller takes at the i-th rising edge.
	task automatic watch(input logic [7:0] exp, input logic cal);
		int k;
		for (int i = 1; i <= READ_LAT + 8; i++) begin
			@(negedge core_clk_i);
			k = i - READ_LAT;
			check(32'(rd.valid), 32'(k >= 0 && k < 8));
			if (k >= 0 && k < 8)
				check(32'(rd.dqs), k % 2 == 0 ? 32'hf : 32'h0);
			if (k == 0 && !cal)
				check(32'(rd.dq[7:0]), 32'(exp));
			if (k >= 0 && k < 8 && cal)
				check(rd.dq, {32{exp[k]}});
		end
	endtask : watch

	// Register read with the bus idle for the whole burst.
	task automatic rd_reg(input logic [7:0] idx, input logic [7:0] exp,
		input logic cal);
		ctl_u.reg_read(idx);
		fork
			ctl_u.nop(READ_LAT + 8);
			watch(exp, cal);
		join
		@(posedge core_clk_i);
	endtask : rd_reg

	//**********************************************************************
	// Test sequence
	//**********************************************************************
	initial begin
		failures = 0;
		n_checks = 0;
		cycles = 0;
		sys_rst_i = 1'b1;
		repeat (2) @(posedge core_clk_i);
		#1 sys_rst_i = 1'b0;
		@(posedge core_clk_i);
		check(32'(self_refresh), 32'h0);
		check(32'(bank_ptr), 32'h0);
		check(32'(refresh_done), 32'h0);
		check(32'(bank_retain), 32'hff);
		check(32'(seg_retain), 32'hff);
		$display("Test reset done");
		// Masks, all banks masked, reserved write, readback, patterns.
		ctl_u.reg_write(`BANK_MASK_IDX, 8'hff);
		check(32'(seg_retain), 32'h0);
		ctl_u.reg_write(`BANK_MASK_IDX, 8'h82);
		ctl_u.reg_write(`SEG_MASK_IDX, 8'h84);
		ctl_u.reg_write(`RSVD_MASK_IDX, 8'hff);
		check(32'(bank_retain), 32'h7d);
		check(32'(seg_retain), 32'h7b);
		rd_reg(`BANK_MASK_IDX, 8'h82, 1'b0);
		rd_reg(`SEG_MASK_IDX, 8'h84, 1'b0);
		rd_reg(`CAL_A_IDX, `CAL_A_PATTERN, 1'b1);
		rd_reg(`CAL_B_IDX, `CAL_B_PATTERN, 1'b1);
		$display("Test register access done");
		// A second read during a running read is refused.
		ctl_u.reg_read(`BANK_MASK_IDX);
		fork
			begin
				ctl_u.nop(3);
				ctl_u.reg_read(`SEG_MASK_IDX);
				ctl_u.nop(READ_LAT + 4);
			end
			watch(8'h82, 1'b0);
		join
		@(posedge core_clk_i);
		$display("Test interrupted read done");
		// Refresh pointer, self refresh with ignored inputs, exit.
		repeat (3) ctl_u.refresh(1'b0);
		check(32'(bank_ptr), 32'h3);
		ctl_u.refresh(1'b1);
		check(32'(bank_ptr), 32'h0);
		repeat (3) ctl_u.refresh(1'b0);
		ctl_u.sr_enter();
		check(32'(self_refresh), 32'h1);
		check(32'(refresh_done), 32'h7d);
		ctl_u.reg_write(`BANK_MASK_IDX, 8'h00);
		ctl_u.sr_exit();
		check(32'(self_refresh), 32'h0);
		check(32'(bank_ptr), 32'h0);
		ctl_u.refresh(1'b1);
		check(32'(bank_retain), 32'h7d);
		rd_reg(`BANK_MASK_IDX, 8'h82, 1'b0);
		$display("Test self refresh done");
		finish_test();
	end
endmodule : dram_self_refresh_mode_read_tb
